// File: hdl/psm_params.svh
// psm_params.svh: constants of the power-saving mode controller.
// assumes inclusion by bare name from hdl/ sources; definitions only.
`ifndef PSM_PARAMS_SVH
`define PSM_PARAMS_SVH

// ----------------------------------------
// power control register
// ----------------------------------------
`define PSM_POWER_CONTROL_ADDR       8'h87
`define PSM_POWER_CONTROL_RESET      8'h00
`define PSM_BIT_IDLE        0
`define PSM_BIT_PDOWN       1
`define PSM_BIT_TX_CLK2     2
`define PSM_BIT_RX_CLK2     3
`define PSM_BIT_ADC_IE      4
`define PSM_BIT_LVR_DIS     5
`define PSM_BIT_BAUD2       6
`define PSM_BIT_BAUD1       7
`define PSM_UNMAPPED_DATA   8'h00

// ----------------------------------------
// timing, in oscillator clocks and machine cycles
// ----------------------------------------
`define PSM_OSC_PER_MC      12
`define PSM_EXT_RST_MC      2
`define PSM_RESTART_MC      3
`define PSM_MC_CNT_W        4

`endif

// File: hdl/psm_pkg.sv
// psm_pkg: types of the power-saving mode controller.
// assumes nothing beyond a SystemVerilog compiler.
package psm_pkg;

  typedef enum logic [1:0] {
    PSM_RUN,
    PSM_IDLE,
    PSM_PDOWN,
    PSM_RESTART
  } psm_state_type;

  // power control register layout, bit 7 first
  typedef struct packed {
    logic baud_double;
    logic second_baud_double;
    logic lvr_disable;
    logic adc_int_enable;
    logic second_rx_clk_sel;
    logic second_tx_clk_sel;
    logic powerdown_req;
    logic idle_req;
  } psm_power_control_type;

  typedef struct packed {
    logic baud_double;
    logic second_baud_double;
    logic second_rx_clk_sel;
    logic second_tx_clk_sel;
  } psm_uart_cfg_type;

  // clock and gating controls toward the rest of the chip
  typedef struct packed {
    logic cpu_halt;
    logic osc_stop;
    logic periph_clk_en;
    logic periph_disable;
    logic port_hold;
    logic lvd_active;
  } psm_power_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psm_sfr_req_type;

endpackage

// File: hdl/psm_tick_div.sv
// psm_tick_div: divides the oscillator clock into a one-cycle enable pulse.
// assumes a free-running clk; reset restarts the count.
`timescale 1ns/1ps
`include "psm_params.svh"
module psm_tick_div #(
  parameter int DIV = `PSM_OSC_PER_MC
) (
  input  wire logic clk,    // oscillator clock
  input  wire logic reset,  // async, active high
  input  wire logic clear,  // restart the period
  output logic      tick    // one-cycle pulse every DIV clocks
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (clear || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= !clear && cnt_q == LAST;
    end
  end

endmodule

// File: hdl/psm_power_control.sv
// psm_power_control: idle and power-down control with the power control register.
// assumes the cpu presents special function register accesses on clk, one cycle each,
// and that an outside clock unit gates clocks from the power outputs.
`timescale 1ns/1ps
`include "psm_params.svh"
module psm_power_control
  import psm_pkg::*;
#(
  parameter int OSC_PER_MC = `PSM_OSC_PER_MC,
  parameter int EXT_RST_MC = `PSM_EXT_RST_MC,
  parameter int RESTART_MC = `PSM_RESTART_MC
) (
  input  wire logic             clk,             // oscillator clock, 25 MHz
  input  wire logic             reset,           // async power-on reset, active high
  input  wire psm_sfr_req_type  sfr_req,         // register access from the cpu
  output psm_power_control_type          sfr_rdata_q,     // read data of the last read
  output logic                  sfr_hit_q,       // read in the previous cycle hit this register
  input  wire logic             int_request,     // any enabled interrupt pending
  input  wire logic             ext_reset_n_pin, // reset pin, active low, async
  input  wire logic             lvr_trip_pin,    // supply below threshold, async
  input  wire logic             wdt_overflow,    // watchdog overflow pulse
  input  wire logic             usb_reset,       // usb bus reset request
  output psm_power_type         power_q,         // clock and gating controls
  output psm_uart_cfg_type      uart_cfg_q,      // uart configuration bits
  output logic                  adc_int_en_q,    // adc interrupt enable
  output logic                  lvr_enable_q,    // low-voltage reset armed
  output logic                  int_reset_q,     // internal reset to the core
  output logic                  idle_wake_q,     // pulse: idle ended by interrupt
  output psm_state_type         state_q          // present mode
);

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam logic [`PSM_MC_CNT_W-1:0] EXT_LAST = `PSM_MC_CNT_W'(EXT_RST_MC);
  localparam logic [`PSM_MC_CNT_W-1:0] RST_LAST = `PSM_MC_CNT_W'(RESTART_MC);
  localparam logic [`PSM_MC_CNT_W-1:0] ONE_MC   = `PSM_MC_CNT_W'(1);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  psm_power_control_type                power_control_q;
  psm_power_control_type                wr_val;
  psm_state_type               state_d;
  logic                        mc_tick;
  logic                        power_control_wr;
  logic                        ext_meta_q;
  logic                        ext_sync_q;
  logic                        lvr_meta_q;
  logic                        lvr_sync_q;
  logic [`PSM_MC_CNT_W-1:0]    ext_cnt_q;
  logic                        ext_rst_q;
  logic [`PSM_MC_CNT_W-1:0]    rst_cnt_q;
  logic                        any_reset;
  logic                        wake_int;

  assign power_control_wr   = sfr_req.wr && sfr_req.addr == `PSM_POWER_CONTROL_ADDR;
  assign wr_val    = psm_power_control_type'(sfr_req.wdata);
  // low-voltage reset honoured in every mode unless disabled
  assign any_reset = ext_rst_q || wdt_overflow || usb_reset ||
                     (lvr_sync_q && !power_control_q.lvr_disable);
  // only idle ends on interrupt, power-down ignores it
  assign wake_int  = state_q == PSM_IDLE && int_request;

  // ----------------------------------------
  // machine-cycle enable
  // ----------------------------------------
  psm_tick_div #(
    .DIV   (OSC_PER_MC)
  ) u_mc_div (
    .clk   (clk),
    .reset (reset),
    .clear (1'b0),
    .tick  (mc_tick)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= !ext_reset_n_pin;
      ext_sync_q <= ext_meta_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lvr_meta_q <= 1'b0;
      lvr_sync_q <= 1'b0;
    end else begin
      lvr_meta_q <= lvr_trip_pin;
      lvr_sync_q <= lvr_meta_q;
    end
  end

  // ----------------------------------------
  // external reset qualification
  // ----------------------------------------
  // a glitch shorter than one machine cycle never resets the core
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_cnt_q <= '0;
    end else if (!ext_sync_q) begin
      ext_cnt_q <= '0;
    end else if (mc_tick && ext_cnt_q != EXT_LAST) begin
      ext_cnt_q <= ext_cnt_q + ONE_MC;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_rst_q <= 1'b0;
    end else begin
      ext_rst_q <= ext_sync_q && ext_cnt_q == EXT_LAST;
    end
  end

  // ----------------------------------------
  // power control register
  // ----------------------------------------
  // internal reset returns every bit to its reset value, power-up included
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_control_q <= psm_power_control_type'(`PSM_POWER_CONTROL_RESET);
    end else if (any_reset) begin
      power_control_q <= psm_power_control_type'(`PSM_POWER_CONTROL_RESET);
    end else if (power_control_wr) begin
      power_control_q <= wr_val;
      // a write of 1 beats a same-cycle interrupt clear
      if (!wr_val.idle_req && wake_int) begin
        power_control_q.idle_req <= 1'b0;
      end
    end else if (wake_int) begin
      power_control_q.idle_req <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sfr_rdata_q <= psm_power_control_type'(`PSM_UNMAPPED_DATA);
      sfr_hit_q   <= 1'b0;
    end else if (sfr_req.rd) begin
      sfr_hit_q <= sfr_req.addr == `PSM_POWER_CONTROL_ADDR;
      if (sfr_req.addr == `PSM_POWER_CONTROL_ADDR) begin
        sfr_rdata_q <= power_control_q;
      end else begin
        sfr_rdata_q <= psm_power_control_type'(`PSM_UNMAPPED_DATA);
      end
    end else begin
      sfr_hit_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // mode sequencing
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      PSM_RUN: begin
        if (power_control_wr && wr_val.powerdown_req) begin
          state_d = PSM_PDOWN;
        end else if (power_control_wr && wr_val.idle_req) begin
          state_d = PSM_IDLE;
        end
      end
      PSM_IDLE: begin
        if (wake_int) begin
          state_d = PSM_RUN;
        end
      end
      PSM_PDOWN: begin
        state_d = PSM_PDOWN;
      end
      PSM_RESTART: begin
        if (!any_reset && mc_tick && rst_cnt_q == RST_LAST - ONE_MC) begin
          state_d = PSM_RUN;
        end
      end
      default: begin
        state_d = PSM_RUN;
      end
    endcase
    if (any_reset) begin
      state_d = PSM_RESTART;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= PSM_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // restart delay counted in machine cycles once the source lets go
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_cnt_q <= '0;
    end else if (any_reset || state_q != PSM_RESTART) begin
      rst_cnt_q <= '0;
    end else if (mc_tick && rst_cnt_q != RST_LAST) begin
      rst_cnt_q <= rst_cnt_q + ONE_MC;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      int_reset_q <= 1'b0;
    end else begin
      int_reset_q <= any_reset;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_wake_q <= 1'b0;
    end else begin
      idle_wake_q <= wake_int && !any_reset;
    end
  end

  // ----------------------------------------
  // power and gating outputs
  // ----------------------------------------
  // the clock unit stops the oscillator from osc_stop; the reset path must
  // restart it without this clock, so osc_stop falls under reset asynchronously
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_q <= '{cpu_halt: 1'b0, osc_stop: 1'b0, periph_clk_en: 1'b1,
                   periph_disable: 1'b0, port_hold: 1'b0, lvd_active: 1'b1};
    end else begin
      power_q.cpu_halt       <= state_d != PSM_RUN;
      power_q.osc_stop       <= state_d == PSM_PDOWN;
      power_q.periph_clk_en  <= state_d != PSM_PDOWN;
      power_q.periph_disable <= state_d == PSM_PDOWN;
      power_q.port_hold      <= state_d == PSM_PDOWN;
      power_q.lvd_active     <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      uart_cfg_q   <= '0;
      adc_int_en_q <= 1'b0;
      lvr_enable_q <= 1'b1;
    end else begin
      uart_cfg_q   <= '{baud_double:        power_control_q.baud_double,
                        second_baud_double: power_control_q.second_baud_double,
                        second_rx_clk_sel:  power_control_q.second_rx_clk_sel,
                        second_tx_clk_sel:  power_control_q.second_tx_clk_sel};
      adc_int_en_q <= power_control_q.adc_int_enable;
      lvr_enable_q <= !power_control_q.lvr_disable;
    end
  end

endmodule

// File: bench/psm_power_control_chk.sv
// psm_power_control_chk: assertions on the power control ports.
// assumes a bind to psm_power_control; one clock, async reset.
`timescale 1ns/1ps
module psm_power_control_chk
  import psm_pkg::*;
#(
  parameter int OSC_PER_MC = 12,
  parameter int EXT_RST_MC = 2,
  parameter int RESTART_MC = 3
) (
  input wire logic             clk,             // clock
  input wire logic             reset,           // async reset
  input wire psm_sfr_req_type  sfr_req,         // access
  input wire psm_power_control_type     sfr_rdata_q,     // read data
  input wire logic             sfr_hit_q,       // read hit
  input wire logic             int_request,     // interrupt
  input wire logic             ext_reset_n_pin, // reset pin
  input wire logic             lvr_trip_pin,    // supply low
  input wire logic             wdt_overflow,    // watchdog
  input wire logic             usb_reset,       // usb reset
  input wire psm_power_type    power_q,         // controls
  input wire psm_uart_cfg_type uart_cfg_q,      // uart bits
  input wire logic             adc_int_en_q,    // adc enable
  input wire logic             lvr_enable_q,    // lvr armed
  input wire logic             int_reset_q,     // internal reset
  input wire logic             idle_wake_q,     // wake pulse
  input wire psm_state_type    state_q          // mode
);
  // restart lasts three machine cycles from a release at any tick phase
  localparam int RST_LO = OSC_PER_MC * (RESTART_MC - 1) - 2;
  localparam int RST_HI = OSC_PER_MC * RESTART_MC + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // watchdog and usb resets hold the register at zero, so those writes are left out, as are all writes in restart
  wire power_control_wr = sfr_req.wr && sfr_req.addr == 8'h87 && !wdt_overflow && !usb_reset && state_q != PSM_RESTART;
  logic [7:0] last_wd_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) last_wd_q <= 8'h00;
    else if (power_control_wr) last_wd_q <= sfr_req.wdata;
  end
  sequence s_wake;
    state_q == PSM_RUN && idle_wake_q && !power_q.cpu_halt ##1 !idle_wake_q;
  endsequence
  sequence s_restart_done;
    ##[RST_LO:RST_HI] (state_q == PSM_RUN && !power_q.cpu_halt);
  endsequence
  chk_idle_entry: assert property (power_control_wr && state_q == PSM_RUN && sfr_req.wdata[1:0] == 2'h1
    |=> state_q == PSM_IDLE && power_q.cpu_halt) else $error("idle not entered");
  chk_pdown_entry: assert property (power_control_wr && state_q == PSM_RUN && sfr_req.wdata[1]
    |=> state_q == PSM_PDOWN && power_q == 6'h37) else $error("power-down not entered");
  chk_idle_wake: assert property (state_q == PSM_IDLE && int_request && !wdt_overflow && !usb_reset
    |=> s_wake) else $error("interrupt did not end idle");
  chk_pdown_stays: assert property (state_q == PSM_PDOWN && int_request && !wdt_overflow && !usb_reset
    |=> state_q == PSM_PDOWN) else $error("interrupt ended power-down");
  chk_sync_reset: assert property (wdt_overflow || usb_reset
    |=> int_reset_q && state_q == PSM_RESTART && power_q.cpu_halt) else $error("reset not taken");
  chk_restart_len: assert property ($fell(int_reset_q) |-> s_restart_done)
    else $error("restart length wrong");
  chk_read_hit: assert property (sfr_req.rd
    |=> sfr_hit_q == ($past(sfr_req.addr) == 8'h87)) else $error("read hit wrong");
  chk_cfg_follow: assert property (power_control_wr ##1 !sfr_req.wr && !wdt_overflow && !usb_reset
    |=> uart_cfg_q == {last_wd_q[7:6], last_wd_q[3:2]} && adc_int_en_q == last_wd_q[4]
        && lvr_enable_q == !last_wd_q[5]) else $error("config bits wrong");
  chk_idle_runs: assert property (state_q == PSM_IDLE
    |-> power_q == 6'h29) else $error("idle controls wrong");
  chk_lvd_on: assert property (power_q.lvd_active) else $error("detector off");
endmodule

bind psm_power_control psm_power_control_chk #(.OSC_PER_MC(OSC_PER_MC), .EXT_RST_MC(EXT_RST_MC),
  .RESTART_MC(RESTART_MC)) u_chk (.clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q),
  .sfr_hit_q(sfr_hit_q), .int_request(int_request), .ext_reset_n_pin(ext_reset_n_pin),
  .lvr_trip_pin(lvr_trip_pin), .wdt_overflow(wdt_overflow), .usb_reset(usb_reset), .power_q(power_q),
  .uart_cfg_q(uart_cfg_q), .adc_int_en_q(adc_int_en_q), .lvr_enable_q(lvr_enable_q),
  .int_reset_q(int_reset_q), .idle_wake_q(idle_wake_q), .state_q(state_q));

// File: bench/tb.sv
// tb: self-checking bench for the power control block.
// assumes design sources and checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  import psm_pkg::*;
  localparam int IRQ = 0, EXT = 1, LOW_VOLTAGE_RESET = 2, WDT = 3, USB = 4;
  logic             clk, reset, int_request, ext_reset_n_pin, lvr_trip_pin, wdt_overflow, usb_reset;
  logic             sfr_hit_q, adc_int_en_q, lvr_enable_q, int_reset_q, idle_wake_q;
  psm_sfr_req_type  sfr_req;
  psm_power_control_type     sfr_rdata_q;
  psm_power_type    power_q;
  psm_uart_cfg_type uart_cfg_q;
  psm_state_type    state_q;
  int               n_fail, n_tests, cycles;
  logic [7:0]       tbl [3] = '{8'h54, 8'hA8, 8'hFC};
  psm_power_control u_psm_power_control (.clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q),
    .sfr_hit_q(sfr_hit_q), .int_request(int_request), .ext_reset_n_pin(ext_reset_n_pin),
    .lvr_trip_pin(lvr_trip_pin), .wdt_overflow(wdt_overflow), .usb_reset(usb_reset), .power_q(power_q),
    .uart_cfg_q(uart_cfg_q), .adc_int_en_q(adc_int_en_q), .lvr_enable_q(lvr_enable_q),
    .int_reset_q(int_reset_q), .idle_wake_q(idle_wake_q), .state_q(state_q));
  // ----------------------------------------
  // tasks: reporting, register access, pin drive and restart wait
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) sfr_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk) sfr_req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) sfr_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clk) sfr_req <= '0;
    #1;
    `CHK("hit", a == 8'h87, sfr_hit_q)
    `CHK("rdata", e, sfr_rdata_q)
  endtask
  // nonblocking writes to a ref argument are not portable, hence the selector
  task automatic set(input int k, input logic v);
    case (k)
      IRQ: int_request <= v;
      EXT: ext_reset_n_pin <= v;
      LOW_VOLTAGE_RESET: lvr_trip_pin <= v;
      WDT: wdt_overflow <= v;
      default: usb_reset <= v;
    endcase
  endtask
  task automatic drive(input int k, input logic v, input int n);
    @(posedge clk) set(k, v);
    repeat (n) @(posedge clk);
    set(k, ~v);
    #1;
  endtask
  // counts edges from the call until the restart has let go, sampling off the edge
  task automatic wait_run(input int lo, input int hi);
    int n;
    n = 0;
    while (state_q !== PSM_RUN && n < 100) begin
      @(posedge clk) #1;
      n++;
    end
    `CHK("restart", PSM_RUN, state_q)
    `CHK("restart_len", 1'b1, n >= lo && n <= hi)
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    reset = 1'h1;
    sfr_req = '0;
    {int_request, lvr_trip_pin, wdt_overflow, usb_reset} = 4'h0;
    ext_reset_n_pin = 1'h1;
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    #1;
    `CHK("power", 6'h09, power_q)
    `CHK("lvr_en", 1'h1, lvr_enable_q)
    rd(8'h87, 8'h00);
    rd(8'h30, 8'h00);
    foreach (tbl[i]) begin
      wr(8'h87, tbl[i]);
      @(posedge clk) #1;
      `CHK("uart", {tbl[i][7:6], tbl[i][3:2]}, uart_cfg_q)
      `CHK("adc", tbl[i][4], adc_int_en_q)
      `CHK("lvr_en", !tbl[i][5], lvr_enable_q)
      rd(8'h87, tbl[i]);
    end
    wr(8'h88, 8'h03);
    rd(8'h87, 8'hFC);
    `CHK("state", PSM_RUN, state_q)
    drive(LOW_VOLTAGE_RESET, 1'h1, 10);
    `CHK("state", PSM_RUN, state_q)
    wr(8'h87, 8'h01);
    `CHK("state", PSM_IDLE, state_q)
    `CHK("power", 6'h29, power_q)
    repeat (5) @(posedge clk);
    drive(IRQ, 1'h1, 1);
    `CHK("state", PSM_RUN, state_q)
    `CHK("wake", 1'h1, idle_wake_q)
    rd(8'h87, 8'h00);
    wr(8'h87, 8'h03);
    `CHK("state", PSM_PDOWN, state_q)
    `CHK("power", 6'h37, power_q)
    drive(IRQ, 1'h1, 3);
    `CHK("state", PSM_PDOWN, state_q)
    rd(8'h87, 8'h03);
    drive(USB, 1'h1, 1);
    `CHK("int_rst", 1'h1, int_reset_q)
    `CHK("state", PSM_RESTART, state_q)
    // three machine cycles after release, tick phase unknown
    wait_run(25, 36);
    rd(8'h87, 8'h00);
    wr(8'h87, 8'h01);
    drive(WDT, 1'h1, 1);
    `CHK("state", PSM_RESTART, state_q)
    wait_run(25, 36);
    wr(8'h87, 8'h01);
    drive(EXT, 1'h0, 5);
    repeat (5) @(posedge clk);
    `CHK("state", PSM_IDLE, state_q)
    drive(EXT, 1'h0, 50);
    `CHK("state", PSM_RESTART, state_q)
    // two synchroniser flops and the qualifier flop add to the delay
    wait_run(28, 39);
    wr(8'h87, 8'h02);
    drive(LOW_VOLTAGE_RESET, 1'h1, 5);
    `CHK("state", PSM_RESTART, state_q)
    wait_run(27, 38);
    // power-on reset in mid-run, from power-down with the low-voltage reset disabled
    wr(8'h87, 8'h22);
    @(posedge clk) reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    #1;
    `CHK("state", PSM_RUN, state_q)
    `CHK("power", 6'h09, power_q)
    `CHK("lvr_en", 1'h1, lvr_enable_q)
    rd(8'h87, 8'h00);
    stop_test();
  end
endmodule
